/* src/hbp_params.svh */
// timing counts, address window and reset values for the host bus port
`ifndef HBP_PARAMS_SVH
`define HBP_PARAMS_SVH

// core clock period
`define HBP_CLK_PERIOD_NS   5

// fixed-time read valid limits (longest times, round down)
`define HBP_TRO8_NS         540
`define HBP_TRO16_NS        570
`define HBP_TRO8_CYC        ((`HBP_TRO8_NS) / (`HBP_CLK_PERIOD_NS))
`define HBP_TRO16_CYC       ((`HBP_TRO16_NS) / (`HBP_CLK_PERIOD_NS))

// fixed-time write hold minimums (least times, round up)
`define HBP_TWP8_NS         540
`define HBP_TWP16_NS        570
`define HBP_TWP8_CYC        ((`HBP_TWP8_NS + `HBP_CLK_PERIOD_NS - 1) / (`HBP_CLK_PERIOD_NS))
`define HBP_TWP16_CYC       ((`HBP_TWP16_NS + `HBP_CLK_PERIOD_NS - 1) / (`HBP_CLK_PERIOD_NS))

// memory ownership of one scan transfer
`define HBP_SCAN_OWN_NS     450
`define HBP_SCAN_OWN_CYC    ((`HBP_SCAN_OWN_NS) / (`HBP_CLK_PERIOD_NS))

// cycles per byte access on the buffer sram
`define HBP_BYTE_CYC        4

// occupied host window, last byte address
`define HBP_WIN_LAST        11'h4ff

// strobe synchroniser depth and idle level
`define HBP_SYNC_STAGES     2
`define HBP_STROBE_IDLE     3'h7

// timer width
`define HBP_CNT_W           8

`endif

/* src/hbp_pkg.sv */
// types shared by the host bus port modules
package hbp_pkg;

    typedef logic [10:0] hbp_addr_t;
    typedef logic [15:0] hbp_word_t;

    typedef enum logic [2:0] {
        HS_IDLE  = 3'b000,
        HS_GRANT = 3'b001,
        HS_RBUSY = 3'b010,
        HS_READY = 3'b011,
        HS_WCAP  = 3'b100,
        HS_WBUSY = 3'b101
    } hbp_host_state_e;

    typedef enum logic [1:0] {
        AS_IDLE = 2'b00,
        AS_SCAN = 2'b01,
        AS_HOST = 2'b10
    } hbp_arb_state_e;

endpackage : hbp_pkg

/* src/hbp_arb_if.sv */
// request and grant signals between the port logic and the sram arbiter
`timescale 1ns/10ps

interface hbp_arb_if;
    logic host_req;
    logic scan_req;
    logic op_busy;
    logic host_gnt;
    logic scan_gnt;
    logic scan_start;
    logic scan_end;

    modport port (
        output host_req,
        output scan_req,
        output op_busy,
        input  host_gnt,
        input  scan_gnt,
        input  scan_start,
        input  scan_end
    );

    modport arb (
        input  host_req,
        input  scan_req,
        input  op_busy,
        output host_gnt,
        output scan_gnt,
        output scan_start,
        output scan_end
    );
endinterface : hbp_arb_if

/* src/hbp_sync.sv */
// two-stage synchroniser for the host strobes
`timescale 1ns/10ps

module hbp_sync #(
    parameter int          WIDTH   = 3,
    parameter logic [WIDTH-1:0] RST_VAL = '1
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    // levels
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            logic meta_q;
            logic sync_q;
            always_ff @(posedge clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    meta_q <= RST_VAL[gi];
                    sync_q <= RST_VAL[gi];
                end else begin
                    meta_q <= async_i[gi];
                    sync_q <= meta_q;
                end
            end
            assign sync_o[gi] = sync_q;
        end
    endgenerate
endmodule : hbp_sync

/* src/hbp_arbiter.sv */
// buffer sram ownership arbiter between host port and scan engine
`timescale 1ns/10ps
`include "hbp_params.svh"

module hbp_arbiter import hbp_pkg::*; #(
    parameter int SCAN_OWN_CYC = `HBP_SCAN_OWN_CYC
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // requests and grants
    hbp_arb_if.arb    arb
);
    localparam logic [7:0] OWN_LAST = 8'(SCAN_OWN_CYC - 1);

    hbp_arb_state_e st_q;
    logic [7:0]     own_cnt_q;
    logic           scan_fin;

    assign scan_fin = (own_cnt_q >= OWN_LAST) && !arb.op_busy;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= AS_IDLE;
        end else begin
            unique case (st_q)
                AS_IDLE: begin
                    if (arb.host_req) begin
                        st_q <= AS_HOST;
                    end else if (arb.scan_req) begin
                        st_q <= AS_SCAN;
                    end
                end
                AS_SCAN: begin
                    if (scan_fin) begin
                        st_q <= AS_IDLE;
                    end
                end
                AS_HOST: begin
                    if (!arb.host_req && !arb.op_busy) begin
                        st_q <= AS_IDLE;
                    end
                end
                default: st_q <= AS_IDLE;
            endcase
        end
    end

    // ownership window of one scan transfer
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            own_cnt_q <= 8'h00;
        end else if (st_q != AS_SCAN) begin
            own_cnt_q <= 8'h00;
        end else if (own_cnt_q < OWN_LAST) begin
            own_cnt_q <= own_cnt_q + 8'h01;
        end
    end

    assign arb.host_gnt   = (st_q == AS_HOST);
    assign arb.scan_gnt   = (st_q == AS_SCAN);
    assign arb.scan_start = (st_q == AS_IDLE) && !arb.host_req && arb.scan_req;
    assign arb.scan_end   = (st_q == AS_SCAN) && scan_fin;
endmodule : hbp_arbiter

/* src/hbp_host_port.sv */
// parallel host port with arbitrated access to the external buffer sram
//
// How it works
// - swap low, 8-bit: invert lowest address bit
// - 16-bit bus ignores the swap input
// - width select low 8-bit, high 16-bit
// - 16-bit skips address bit 0, uses sixteen lines
// - only select plus address 000H to 4FFH
// - reads need select and read strobe low
// - write ends when either strobe rises, capture
// - acknowledge low on access, high when done
// - every access goes to the buffer sram
// - idle arbiter serves the scan engine
// - arbiter grants host when no scan running
// - host waits for a running scan transfer
// - scan waits for a running host access
// - scan transfers happen only in host gaps
// - fixed-time mode uses worst-case access time
// - read data valid by 540/570 ns
// - read strobe low, raised around write pulses
// - each scan transfer owns memory 450 ns
`timescale 1ns/10ps
`include "hbp_params.svh"

module hbp_host_port import hbp_pkg::*; #(
    parameter int TRO8_CYC     = `HBP_TRO8_CYC,
    parameter int TRO16_CYC    = `HBP_TRO16_CYC,
    parameter int TWP8_CYC     = `HBP_TWP8_CYC,
    parameter int TWP16_CYC    = `HBP_TWP16_CYC,
    parameter int SCAN_OWN_CYC = `HBP_SCAN_OWN_CYC,
    parameter int BYTE_CYC     = `HBP_BYTE_CYC
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    // host bus
    input  wire logic [10:0] host_addr_i,
    input  wire logic [15:0] host_data_i,
    output logic      [15:0] host_data_o,
    output logic      [1:0]  host_data_oe_o,
    input  wire logic        host_select_n_i,
    input  wire logic        host_read_n_i,
    input  wire logic        host_write_n_i,
    output logic             host_ack_o,
    // configuration straps
    input  wire logic        bus_width_select_i,
    input  wire logic        byte_swap_n_i,
    input  wire logic        arbiter_enable_n_i,
    input  wire logic        arbiter_auto_enable_n_i,
    // scan engine memory port
    input  wire logic        scan_req_i,
    input  wire logic        scan_we_i,
    input  wire logic [10:0] scan_addr_i,
    input  wire logic [15:0] scan_wdata_i,
    output logic             scan_gnt_o,
    output logic             scan_done_o,
    output logic      [15:0] scan_rdata_o,
    // buffer sram
    output logic      [10:0] mem_addr_o,
    input  wire logic [7:0]  mem_data_i,
    output logic      [7:0]  mem_data_o,
    output logic             mem_data_oe_o,
    output logic             mem_read_n_o,
    output logic             mem_write_n_o
);
    localparam int         CW       = `HBP_CNT_W;
    // read limits also absorb the recognition edge and the ack flop
    localparam logic [CW-1:0] LIM_R8  = CW'(TRO8_CYC - `HBP_SYNC_STAGES - 2);
    localparam logic [CW-1:0] LIM_R16 = CW'(TRO16_CYC - `HBP_SYNC_STAGES - 2);
    localparam logic [CW-1:0] LIM_W8  = CW'(TWP8_CYC - `HBP_SYNC_STAGES);
    localparam logic [CW-1:0] LIM_W16 = CW'(TWP16_CYC - `HBP_SYNC_STAGES);
    localparam logic [2:0]    PC_LAST = 3'(BYTE_CYC - 1);
    localparam logic [2:0]    PC_WEND = 3'(BYTE_CYC - 3);

    hbp_arb_if arb_bus ();

    // synchronised strobes
    logic [2:0]      strobe_s;
    logic            sel_n_s;
    logic            rd_n_s;
    logic            wr_n_s;
    // host side
    hbp_host_state_e hst_q;
    logic            in_window;
    logic            rd_act;
    logic            wr_act;
    logic            wide;
    logic            fixed_mode;
    hbp_addr_t       map_addr;
    hbp_addr_t       hop_addr_q;
    logic            hop_wide_q;
    logic            hop_wr_q;
    hbp_word_t       hop_wdata_q;
    logic [CW-1:0]   tmr_q;
    logic [CW-1:0]   limit_q;
    logic            time_up;
    logic            ack_q;
    hbp_word_t       host_rdata_q;
    logic            op_start_host;
    // sram sequencer
    logic            busy_q;
    logic [2:0]      pc_q;
    logic            bi_q;
    logic            cur_we_q;
    logic            cur_wide_q;
    logic            cur_host_q;
    hbp_addr_t       cur_addr_q;
    hbp_word_t       cur_wdata_q;
    hbp_word_t       rd_buf_q;
    logic            op_done_q;
    hbp_word_t       scan_rdata_q;
    logic            mem_read_n_q;
    logic            mem_write_n_q;
    logic            byte_end;
    logic            op_end;

    hbp_sync #(
        .WIDTH   (3),
        .RST_VAL (`HBP_STROBE_IDLE)
    ) u_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .async_i ({host_select_n_i, host_read_n_i, host_write_n_i}),
        .sync_o  (strobe_s)
    );

    assign sel_n_s = strobe_s[2];
    assign rd_n_s  = strobe_s[1];
    assign wr_n_s  = strobe_s[0];

    hbp_arbiter #(
        .SCAN_OWN_CYC (SCAN_OWN_CYC)
    ) u_arb (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .arb     (arb_bus.arb)
    );

    // access recognition
    assign wide       = bus_width_select_i;
    assign in_window  = (host_addr_i <= `HBP_WIN_LAST);
    assign rd_act     = !sel_n_s && !rd_n_s && in_window;
    assign wr_act     = !sel_n_s && !wr_n_s && in_window && rd_n_s;
    assign fixed_mode = !arbiter_enable_n_i && arbiter_auto_enable_n_i;

    // byte address seen by the sram
    always_comb begin
        if (wide) begin
            map_addr = {host_addr_i[10:1], 1'b0};
        end else begin
            map_addr = {host_addr_i[10:1], host_addr_i[0] ^ !byte_swap_n_i};
        end
    end

    // host access sequence
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hst_q <= HS_IDLE;
        end else begin
            unique case (hst_q)
                HS_IDLE: begin
                    if (rd_act || wr_act) begin
                        hst_q <= HS_GRANT;
                    end
                end
                HS_GRANT: begin
                    if (arb_bus.host_gnt) begin
                        hst_q <= hop_wr_q ? HS_WCAP : HS_RBUSY;
                    end
                end
                HS_RBUSY: begin
                    if (op_done_q) begin
                        hst_q <= HS_READY;
                    end
                end
                HS_READY: begin
                    if (!rd_act) begin
                        hst_q <= HS_IDLE;
                    end
                end
                HS_WCAP: begin
                    if (!wr_act) begin
                        hst_q <= HS_WBUSY;
                    end
                end
                HS_WBUSY: begin
                    if (op_done_q) begin
                        hst_q <= HS_IDLE;
                    end
                end
                default: hst_q <= HS_IDLE;
            endcase
        end
    end

    // access parameters caught at recognition
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hop_addr_q <= 11'h000;
            hop_wide_q <= 1'b1;
            hop_wr_q   <= 1'b0;
            limit_q    <= '0;
        end else if (hst_q == HS_IDLE && (rd_act || wr_act)) begin
            hop_addr_q <= map_addr;
            hop_wide_q <= wide;
            hop_wr_q   <= !rd_act;
            if (!fixed_mode) begin
                limit_q <= '0;
            end else if (rd_act) begin
                limit_q <= wide ? LIM_R16 : LIM_R8;
            end else begin
                limit_q <= wide ? LIM_W16 : LIM_W8;
            end
        end
    end

    // write data sampled while both strobes are low
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hop_wdata_q <= 16'h0000;
        end else if ((hst_q == HS_IDLE || hst_q == HS_GRANT || hst_q == HS_WCAP) && wr_act) begin
            hop_wdata_q <= hop_wide_q || hst_q == HS_IDLE && wide ? host_data_i : {8'h00, host_data_i[7:0]};
        end
    end

    // access timer from recognition
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tmr_q <= '0;
        end else if (hst_q == HS_IDLE) begin
            tmr_q <= '0;
        end else if (tmr_q != '1) begin
            tmr_q <= tmr_q + 1'b1;
        end
    end

    assign time_up = (tmr_q >= limit_q);

    // acknowledge doubles as wait request
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_q <= 1'b1;
        end else if (hst_q == HS_IDLE && (rd_act || wr_act)) begin
            ack_q <= 1'b0;
        end else if ((hst_q == HS_READY || hst_q == HS_WCAP) && time_up) begin
            ack_q <= 1'b1;
        end else if (hst_q == HS_WBUSY || hst_q == HS_IDLE) begin
            ack_q <= 1'b1;
        end
    end

    // read data held for the host
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            host_rdata_q <= 16'h0000;
        end else if (op_done_q && cur_host_q && !cur_we_q) begin
            host_rdata_q <= cur_wide_q ? rd_buf_q : {8'h00, rd_buf_q[7:0]};
        end
    end

    assign op_start_host = (hst_q == HS_GRANT && arb_bus.host_gnt && !hop_wr_q)
                        || (hst_q == HS_WCAP && !wr_act);

    // sram byte sequencer shared by both owners
    assign byte_end = busy_q && (pc_q == PC_LAST);
    assign op_end   = byte_end && (bi_q == cur_wide_q);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            busy_q      <= 1'b0;
            pc_q        <= 3'h0;
            bi_q        <= 1'b0;
            cur_we_q    <= 1'b0;
            cur_wide_q  <= 1'b0;
            cur_host_q  <= 1'b0;
            cur_addr_q  <= 11'h000;
            cur_wdata_q <= 16'h0000;
        end else if (op_start_host) begin
            busy_q      <= 1'b1;
            pc_q        <= 3'h0;
            bi_q        <= 1'b0;
            cur_we_q    <= hop_wr_q;
            cur_wide_q  <= hop_wide_q;
            cur_host_q  <= 1'b1;
            cur_addr_q  <= hop_addr_q;
            cur_wdata_q <= hop_wdata_q;
        end else if (arb_bus.scan_start) begin
            busy_q      <= 1'b1;
            pc_q        <= 3'h0;
            bi_q        <= 1'b0;
            cur_we_q    <= scan_we_i;
            cur_wide_q  <= 1'b1;
            cur_host_q  <= 1'b0;
            cur_addr_q  <= {scan_addr_i[10:1], 1'b0};
            cur_wdata_q <= scan_wdata_i;
        end else if (op_end) begin
            busy_q <= 1'b0;
            pc_q   <= 3'h0;
        end else if (byte_end) begin
            pc_q <= 3'h0;
            bi_q <= 1'b1;
        end else if (busy_q) begin
            pc_q <= pc_q + 3'h1;
        end
    end

    // read bytes captured at the end of each byte slot
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_buf_q <= 16'h0000;
        end else if (byte_end && !cur_we_q) begin
            if (bi_q) begin
                rd_buf_q[15:8] <= mem_data_i;
            end else begin
                rd_buf_q[7:0] <= mem_data_i;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            op_done_q <= 1'b0;
        end else begin
            op_done_q <= op_end;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            scan_rdata_q <= 16'h0000;
        end else if (op_done_q && !cur_host_q && !cur_we_q) begin
            scan_rdata_q <= rd_buf_q;
        end
    end

    // read strobe low at rest, high and a write pulse inside writes
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mem_read_n_q  <= 1'b0;
            mem_write_n_q <= 1'b1;
        end else begin
            mem_read_n_q  <= busy_q && cur_we_q && !op_end;
            mem_write_n_q <= !(busy_q && cur_we_q && pc_q <= PC_WEND);
        end
    end

    // arbiter hookup
    assign arb_bus.host_req = (hst_q != HS_IDLE);
    assign arb_bus.scan_req = scan_req_i;
    assign arb_bus.op_busy  = busy_q;

    // outputs
    assign host_data_o       = host_rdata_q;
    assign host_data_oe_o[0] = (hst_q == HS_READY) && rd_act;
    assign host_data_oe_o[1] = (hst_q == HS_READY) && rd_act && hop_wide_q;
    assign host_ack_o        = ack_q;
    assign scan_gnt_o        = arb_bus.scan_gnt;
    assign scan_done_o       = arb_bus.scan_end;
    assign scan_rdata_o      = scan_rdata_q;
    assign mem_addr_o        = {cur_addr_q[10:1], cur_addr_q[0] | bi_q};
    assign mem_data_o        = bi_q ? cur_wdata_q[15:8] : cur_wdata_q[7:0];
    assign mem_data_oe_o     = mem_read_n_q;
    assign mem_read_n_o      = mem_read_n_q;
    assign mem_write_n_o     = mem_write_n_q;
endmodule : hbp_host_port

/* testbench/hbp_sram_model.sv */
// behavioural model of the external buffer sram
`timescale 1ns/10ps

module hbp_sram_model (
    // sram pins
    input  wire logic [10:0] addr_i,
    input  wire logic [7:0]  data_i,
    output logic      [7:0]  data_o,
    input  wire logic        read_n_i,
    input  wire logic        write_n_i
);
    logic [7:0] mem [2048];
    logic [7:0] last_q;

    initial begin
        for (int i = 0; i < 2048; i++) mem[i] = i[7:0] ^ 8'h5a;
        last_q = 8'h00;
    end

    // store at the rising end of the write pulse
    always @(posedge write_n_i) mem[addr_i] = data_i;
    always @(posedge read_n_i) last_q = mem[addr_i];
    // released bus shows the inverse of the last value
    assign data_o = read_n_i ? ~last_q : mem[addr_i];
endmodule : hbp_sram_model

/* testbench/hbp_port_monitor.sv */
// assertion checker for the host bus port
`timescale 1ns/10ps

module hbp_port_monitor #(
    parameter int TRO16_CYC = 114,
    parameter int TWP8_CYC  = 108
) (
    // clock, reset and host side
    input wire logic        clk_i,
    input wire logic        rst_n_i,
    input wire logic [10:0] host_addr_i,
    input wire logic [1:0]  host_data_oe_o,
    input wire logic        host_select_n_i,
    input wire logic        host_read_n_i,
    input wire logic        host_ack_o,
    input wire logic        bus_width_select_i,
    input wire logic        arbiter_enable_n_i,
    input wire logic        arbiter_auto_enable_n_i,
    // scan and sram side
    input wire logic        scan_gnt_o,
    input wire logic        scan_done_o,
    input wire logic        mem_data_oe_o,
    input wire logic        mem_read_n_o,
    input wire logic        mem_write_n_o
);
    logic [7:0] low_q;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    // consecutive cycles of acknowledge low
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) low_q <= 8'h00;
        else low_q <= host_ack_o ? 8'h00 : low_q + 8'h01;
    end

    sequence gnt_start; $rose(scan_gnt_o); endsequence
    sequence own_run; scan_gnt_o [*8]; endsequence

    oe_read_a: assert property (|host_data_oe_o |-> !$past(host_select_n_i, 2) && !$past(host_read_n_i, 2))
        else $error("data driven without select and read");
    hi_lane_a: assert property (host_data_oe_o[1] |-> bus_width_select_i)
        else $error("high lane driven on narrow bus");
    ack_sel_a: assert property (!host_ack_o |-> !host_select_n_i)
        else $error("acknowledge low without select");
    idle_ack_a: assert property ((host_select_n_i || host_addr_i > 11'h4ff) [*6] |-> host_ack_o)
        else $error("acknowledge low outside window");
    scan_wait_a: assert property (gnt_start |-> $past(host_ack_o))
        else $error("scan granted during host access");
    scan_own_a: assert property (gnt_start |-> own_run)
        else $error("scan ownership too short");
    scan_end_a: assert property (gnt_start |-> ##[10:30] scan_done_o)
        else $error("scan transfer did not end");
    done_one_a: assert property (scan_done_o |=> !scan_done_o)
        else $error("scan done longer than one cycle");
    mem_wr_a: assert property (!mem_write_n_o |-> mem_read_n_o)
        else $error("write pulse with read strobe low");
    mem_oe_a: assert property (mem_data_oe_o |-> mem_read_n_o)
        else $error("sram data driven with read strobe low");
    read_max_a: assert property (!host_ack_o |-> low_q < TRO16_CYC)
        else $error("host access longer than limit");
    fixed_min_a: assert property ($rose(host_ack_o) && !arbiter_enable_n_i && arbiter_auto_enable_n_i
        && !bus_width_select_i |-> low_q >= TWP8_CYC - 4) else $error("fixed access ended early");
endmodule : hbp_port_monitor

bind hbp_host_port hbp_port_monitor #(.TRO16_CYC(TRO16_CYC), .TWP8_CYC(TWP8_CYC)) mon_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .host_addr_i(host_addr_i), .host_data_oe_o(host_data_oe_o),
    .host_select_n_i(host_select_n_i), .host_read_n_i(host_read_n_i), .host_ack_o(host_ack_o),
    .bus_width_select_i(bus_width_select_i), .arbiter_enable_n_i(arbiter_enable_n_i),
    .arbiter_auto_enable_n_i(arbiter_auto_enable_n_i), .scan_gnt_o(scan_gnt_o), .scan_done_o(scan_done_o),
    .mem_data_oe_o(mem_data_oe_o), .mem_read_n_o(mem_read_n_o), .mem_write_n_o(mem_write_n_o));

/* testbench/hbp_host_port_tb_top.sv */
// self-checking testbench for the host bus port
`timescale 1ns/10ps

module hbp_host_port_tb_top import hbp_pkg::*;;
    localparam int TRO8 = 20, TRO16 = 24, TWP8 = 20, TWP16 = 24;
    localparam logic [28:0] ROWS [5] = '{{1'b0, 1'b0, 11'h000, 16'h00a5}, {1'b0, 1'b0, 11'h001, 16'h003c},
        {1'b0, 1'b1, 11'h4ff, 16'h0077}, {1'b1, 1'b0, 11'h021, 16'hbeef}, {1'b1, 1'b1, 11'h4fe, 16'h1234}};
    logic       clk_i, rst_n_i, sel_n, rd_n, wr_n, ack, wid, swp_n, sreq, swe, sgnt, sdone, mrd_n, mwr_n, moe, bad;
    logic       arb_en_n;
    logic [1:0] hoe;
    logic [7:0] mdi, mdo;
    hbp_addr_t  addr, saddr, maddr, a, ea;
    hbp_word_t  wdat, hdo, swd, srd, d, q, sq;
    int         fails, check_count, cyc, n;

    hbp_host_port #(.TRO8_CYC(TRO8), .TRO16_CYC(TRO16), .TWP8_CYC(TWP8), .TWP16_CYC(TWP16), .SCAN_OWN_CYC(12)) dut_u (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .host_addr_i(addr), .host_data_i(wdat), .host_data_o(hdo),
        .host_data_oe_o(hoe), .host_select_n_i(sel_n), .host_read_n_i(rd_n), .host_write_n_i(wr_n),
        .host_ack_o(ack), .bus_width_select_i(wid), .byte_swap_n_i(swp_n), .arbiter_enable_n_i(arb_en_n),
        .arbiter_auto_enable_n_i(1'b1), .scan_req_i(sreq), .scan_we_i(swe), .scan_addr_i(saddr),
        .scan_wdata_i(swd), .scan_gnt_o(sgnt), .scan_done_o(sdone), .scan_rdata_o(srd), .mem_addr_o(maddr),
        .mem_data_i(mdi), .mem_data_o(mdo), .mem_data_oe_o(moe), .mem_read_n_o(mrd_n), .mem_write_n_o(mwr_n));
    hbp_sram_model mdl_u (.addr_i(maddr), .data_i(mdo), .data_o(mdi), .read_n_i(mrd_n), .write_n_i(mwr_n));

    task automatic tick;
        @(posedge clk_i);
        #1;
    endtask : tick

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report

    task automatic rst_chk;
        chk({ack, hoe, mrd_n, mwr_n, moe, sgnt, sdone, 8'h00}, 16'h8800);
        chk(hdo, 16'h0000);
    endtask : rst_chk

    // one host access, strobes held until acknowledge returns high
    task automatic acc(input logic w, input hbp_addr_t aa, input hbp_word_t dd);
        tick();
        addr = aa;
        wdat = dd;
        sel_n = 1'b0;
        rd_n = w;
        wr_n = !w;
        for (n = 0; ack !== 1'b0 && n < 40; n++) tick();
        chk({15'h0000, n < 40}, 16'h0001);
        for (; ack !== 1'b1 && n < 400; n++) tick();
        q = hdo;
        chk({14'h0000, hoe}, w ? 16'h0000 : {14'h0000, wid, 1'b1});
        // select rises first, ending a write on its own
        sel_n = 1'b1;
        tick();
        rd_n = 1'b1;
        wr_n = 1'b1;
        repeat (4) tick();
    endtask : acc

    task automatic scan(input logic w, input hbp_addr_t aa, input hbp_word_t dd);
        tick();
        sreq = 1'b1;
        swe = w;
        saddr = aa;
        swd = dd;
        for (int i = 0; sdone !== 1'b1 && i < 200; i++) tick();
        sq = srd;
        sreq = 1'b0;
    endtask : scan

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = !clk_i;
    end

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            final_report();
        end
    end

    initial begin
        {rst_n_i, arb_en_n, wid, swp_n, sreq, swe, addr, saddr, wdat, swd, fails, check_count, cyc} = '0;
        {sel_n, rd_n, wr_n} = 3'h7;
        repeat (3) @(posedge clk_i);
        rst_chk();
        tick();
        rst_n_i = 1'b1;
        for (int r = 0; r < 5; r++) begin
            {wid, swp_n, a, d} = ROWS[r];
            acc(1'b1, a, d);
            chk({15'h0000, n >= (wid ? TWP16 : TWP8) - 1}, 16'h0001);
            repeat (12) tick();
            ea = wid ? {a[10:1], 1'b0} : a ^ {10'h000, !swp_n};
            chk({wid ? mdl_u.mem[ea | 11'h001] : 8'h00, mdl_u.mem[ea]}, wid ? d : {8'h00, d[7:0]});
            acc(1'b0, a, 16'h0000);
            chk(q, wid ? d : {8'h00, d[7:0]});
            chk({15'h0000, n <= (wid ? TRO16 : TRO8)}, 16'h0001);
        end
        // host arriving while a scan read owns the sram
        fork
            scan(1'b0, 11'h100, 16'h0000);
            begin
                repeat (2) tick();
                acc(1'b0, 11'h020, 16'h0000);
            end
        join
        chk(sq, 16'h5b5a);
        chk(q, 16'hbeef);
        chk({15'h0000, n <= TRO16}, 16'h0001);
        // scan write arriving during a host write
        fork
            acc(1'b1, 11'h030, 16'h1357);
            begin
                repeat (4) tick();
                scan(1'b1, 11'h200, 16'h1234);
            end
        join
        repeat (12) tick();
        chk({mdl_u.mem[11'h031], mdl_u.mem[11'h030]}, 16'h1357);
        // arbiter enable released: access no longer stretched to the fixed time
        arb_en_n = 1'b1;
        acc(1'b0, 11'h200, 16'h0000);
        chk(q, 16'h1234);
        chk({15'h0000, n < TRO16}, 16'h0001);
        // read strobe alone, then select above the window
        for (int k = 0; k < 2; k++) begin
            tick();
            addr = k ? 11'h500 : 11'h010;
            sel_n = !k[0];
            rd_n = 1'b0;
            bad = 1'b0;
            repeat (12) begin
                tick();
                bad = bad | !ack | (|hoe);
            end
            chk({15'h0000, bad}, 16'h0000);
            sel_n = 1'b1;
            rd_n = 1'b1;
            repeat (4) tick();
        end
        rst_n_i = 1'b0;
        tick();
        rst_chk();
        final_report();
    end
endmodule : hbp_host_port_tb_top
